//--- logic/dbsp_pkg.sv
// Purpose: Shared constants and types for the burst-of-two double-data-rate memory port.
// Assumes: Reference clock of 10 MHz; link pins are sampled, not used as clocks.
// Notes: Register offsets are byte addresses on a 32-bit bus.
package dbsp_pkg;
	localparam int ADDR_W = 20;
	localparam int WORD_W = 18;
	localparam int BYTE_W = 9;
	localparam int BYTES = 2;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 20'h00001;
	localparam int REF_PERIOD_NS = 100;
	localparam int PLL_LOCK_NS = 20000;
	localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int PLL_STOP_NS = 30;
	localparam int PLL_STOP_CYC = (PLL_STOP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int LINK_HALF_MAX_CYC = 16;
	localparam logic [5:0] GAP_LIMIT = 6'(LINK_HALF_MAX_CYC + PLL_STOP_CYC);
	localparam logic [7:0] LOCK_LAST = 8'(PLL_LOCK_CYC - 1);
	localparam int RECAL_CYC = 1024;
	localparam logic [9:0] RECAL_LAST = 10'(RECAL_CYC - 1);
	localparam logic [31:0] REG_CTRL_OFS = 32'h00000000;
	localparam logic [31:0] REG_STATUS_OFS = 32'h00000004;
	localparam logic [31:0] REG_CALCNT_OFS = 32'h00000008;
	localparam int CTRL_CAL_EN_BIT = 0;
	localparam int CTRL_CMD_EN_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h3;
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_LAT2_BIT = 1;
	localparam int ST_HOLD_BIT = 2;
	localparam int ST_QOE_BIT = 3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [1:0] {PLL_OFF, PLL_LOCKING, PLL_LOCKED} dbsp_pll_t;

	typedef struct packed {
		logic k;
		logic k_n;
		logic load_strobe_n;
		logic rw_sel;
		logic [BYTES-1:0] byte_write_sel_n;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] d;
		logic pll_bypass_n;
	} dbsp_link_in_t;

	typedef struct packed {
		logic [WORD_W-1:0] q;
		logic q_oe;
		logic echo_strobe_pos;
		logic echo_strobe_neg;
		logic output_valid_flag;
	} dbsp_link_out_t;

	typedef struct packed {
		logic v;
		logic [ADDR_W-1:0] a;
	} dbsp_cmd_t;

	typedef struct packed {
		logic v;
		logic [ADDR_W-1:0] a;
		logic [WORD_W-1:0] d0;
		logic [BYTES-1:0] m0;
		logic [WORD_W-1:0] d1;
		logic [BYTES-1:0] m1;
	} dbsp_wr_t;

	typedef struct packed {
		dbsp_link_in_t s1;
		dbsp_link_in_t s2;
		dbsp_link_in_t s3;
		dbsp_cmd_t rd1;
		dbsp_cmd_t rd2;
		dbsp_cmd_t wcmd;
		dbsp_wr_t wph;
		dbsp_wr_t hold;
		dbsp_cmd_t burst2;
		dbsp_link_out_t out;
		dbsp_pll_t pll;
		logic [7:0] lock_cnt;
		logic [5:0] gap_cnt;
		logic [9:0] cal_cnt;
		logic [15:0] cal_total;
		logic [1:0] ctrl;
		logic a_ctrl_wr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} dbsp_state_t;
endpackage : dbsp_pkg

//--- logic/dbsp_top.sv
// Purpose: Memory-side logic of a burst-of-two double-data-rate static memory port with AHB-Lite status access.
// Assumes: Both link clock phases are sampled by ref_clk; each link half period spans several ref_clk cycles.
// Notes: Every write is posted into a holding register and committed at the next write's first data edge.
//
// Summary of operation
// RQ1: Each access moves two consecutive 18-bit words.
// RQ2: Read starts with read select high, load strobe low at positive clock rise.
// RQ3: First read word after second following positive rise, second on negative rise.
// RQ4: Reads may issue every positive rise and always run to completion.
// RQ5: After pending reads finish, read outputs float after next positive rise.
// RQ6: Write starts with read select low, load strobe low; write address stored.
// RQ7: Write words arrive next positive rise and following negative rise, then stored.
// RQ8: Back-to-back writes accept one word on every clock phase rise.
// RQ9: Deselected writes finish pending data phases, then inputs are ignored.
// RQ10: Byte select 0 gates bits 8:0, select 1 bits 17:9, per word.
// RQ11: Controller may change byte selects between the two words of a burst.
// RQ12: Controller inserts two or three idle cycles between read and write.
// RQ13: Last write waits in holding registers until the next write commits it.
// RQ14: Reads of just-written addresses return newest data from holding registers.
// RQ15: Controller gives each bank its own load strobe.
// RQ16: Output impedance recalibrates every 1024 clock cycles.
// RQ17: Two free-running echo clocks follow positive and negative input clocks.
// RQ18: Valid flag follows data timing, rising half a cycle before data.
// RQ19: With bypass pin high the PLL locks 20 us after stable clock.
// RQ20: Stopping both input clocks resets the PLL; it relocks afterwards.
// RQ21: Bypass pin low disables the PLL and selects one-cycle read latency.
// RQ22: Powers up deselected with data outputs floating.
// RQ23: First word uses latched address, second the next address.
// RQ24: Read latency is two cycles with PLL, one cycle without.
// RQ25: Load strobe high is a no-op; stopped clock holds outputs.
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module dbsp_top (
	input logic ref_clk,
	input logic rst,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input dbsp_pkg::dbsp_link_in_t link_i,
	output dbsp_pkg::dbsp_link_out_t link_o
);
	import dbsp_pkg::*;

	dbsp_state_t r;
	dbsp_state_t n;
	logic kpos;
	logic kneg;
	logic lat2;
	logic cmd_ok;
	logic sel_v;
	logic [ADDR_W-1:0] sel_a;
	logic flag_src;
	logic mem_we;
	logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

	function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old, input logic [WORD_W-1:0] nw,
			input logic [BYTES-1:0] m);
		logic [WORD_W-1:0] w;
		w = old;
		for (int b = 0; b < BYTES; b++) begin
			if (m[b]) begin
				w[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W]; // [RQ10]
			end
		end
		return w;
	endfunction : merge

	// The newest data may still sit in the holding register, so it overlays the array word.
	function automatic logic [WORD_W-1:0] fwd(input logic [ADDR_W-1:0] a, input dbsp_wr_t h);
		logic [WORD_W-1:0] w;
		w = mem[a];
		if (h.v && h.a == a) begin
			w = merge(w, h.d0, h.m0); // [RQ14]
		end
		if (h.v && (h.a + ADDR_ONE) == a) begin
			w = merge(w, h.d1, h.m1); // [RQ14]
		end
		return w;
	endfunction : fwd

	function automatic logic [31:0] reg_rd(input logic [31:0] a, input dbsp_state_t s);
		logic [31:0] v;
		v = 32'h00000000;
		case (a)
			REG_CTRL_OFS: begin
				v[1:0] = s.ctrl;
			end
			REG_STATUS_OFS: begin
				v[ST_LOCK_BIT] = (s.pll == PLL_LOCKED);
				v[ST_LAT2_BIT] = s.s2.pll_bypass_n;
				v[ST_HOLD_BIT] = s.hold.v;
				v[ST_QOE_BIT] = s.out.q_oe;
			end
			REG_CALCNT_OFS: begin
				v[15:0] = s.cal_total;
			end
			default: begin
				v = 32'h00000000;
			end
		endcase
		return v;
	endfunction : reg_rd

	always_comb begin
		n = r;
		mem_we = 1'b0;
		n.s1 = link_i;
		n.s2 = r.s1;
		n.s3 = r.s2;
		kpos = r.s2.k && !r.s3.k;
		kneg = r.s2.k_n && !r.s3.k_n;
		lat2 = r.s2.pll_bypass_n; // [RQ21] [RQ24]
		cmd_ok = r.ctrl[CTRL_CMD_EN_BIT] && (!lat2 || r.pll == PLL_LOCKED);
		sel_v = lat2 ? r.rd2.v : r.rd1.v; // [RQ24]
		sel_a = lat2 ? r.rd2.a : r.rd1.a;
		flag_src = lat2 ? r.rd2.v : r.rd1.v;

		// Clock supervision: a long gap without link edges counts as a stopped clock.
		if (kpos || kneg) begin
			n.gap_cnt = 6'h00;
		end else if (r.gap_cnt != GAP_LIMIT) begin
			n.gap_cnt = r.gap_cnt + 6'h01;
		end
		case (r.pll)
			PLL_OFF: begin
				n.lock_cnt = 8'h00;
				if (lat2) begin
					n.pll = PLL_LOCKING;
				end
			end
			PLL_LOCKING: begin
				if (!lat2) begin
					n.pll = PLL_OFF; // [RQ21]
				end else if (r.gap_cnt == GAP_LIMIT) begin
					n.lock_cnt = 8'h00;
				end else if (r.lock_cnt == LOCK_LAST) begin
					n.pll = PLL_LOCKED; // [RQ19]
				end else begin
					n.lock_cnt = r.lock_cnt + 8'h01; // [RQ19]
				end
			end
			PLL_LOCKED: begin
				if (!lat2) begin
					n.pll = PLL_OFF;
				end else if (r.gap_cnt == GAP_LIMIT) begin
					n.pll = PLL_LOCKING; // [RQ20]
					n.lock_cnt = 8'h00;
				end
			end
			default: begin
				n.pll = PLL_OFF;
			end
		endcase

		if (kpos) begin
			n.out.echo_strobe_pos = 1'b1; // [RQ17]
			n.out.echo_strobe_neg = 1'b0;
			// Read output stage; in-flight reads are never cancelled.
			if (sel_v) begin
				n.out.q = fwd(sel_a, r.hold); // [RQ3] [RQ23] [RQ4]
				n.out.q_oe = 1'b1;
				n.burst2.v = 1'b1;
				n.burst2.a = sel_a + ADDR_ONE; // [RQ1] [RQ23]
			end else begin
				n.out.q_oe = 1'b0; // [RQ5]
			end
			n.rd2 = r.rd1;
			// First write word; the posted write frees the holding register now.
			n.wph.v = r.wcmd.v;
			if (r.wcmd.v) begin
				n.wph.a = r.wcmd.a; // [RQ7]
				n.wph.d0 = r.s2.d;
				n.wph.m0 = ~r.s2.byte_write_sel_n; // [RQ10]
				if (r.hold.v) begin
					mem_we = 1'b1; // [RQ13]
					n.hold.v = 1'b0;
				end
			end
			// Load strobe high is a no-op; load strobe low is a new command while commands are enabled and, with the PLL on, it is locked.
			n.rd1.v = cmd_ok && !r.s2.load_strobe_n && r.s2.rw_sel; // [RQ2] [RQ25]
			n.rd1.a = r.s2.addr;
			n.wcmd.v = cmd_ok && !r.s2.load_strobe_n && !r.s2.rw_sel; // [RQ6] [RQ8] [RQ9]
			n.wcmd.a = r.s2.addr;
			if (r.ctrl[CTRL_CAL_EN_BIT]) begin
				n.cal_cnt = r.cal_cnt + 10'h001; // [RQ16]
				if (r.cal_cnt == RECAL_LAST) begin
					n.cal_total = r.cal_total + 16'h0001; // [RQ16]
				end
			end
		end

		if (kneg) begin
			n.out.echo_strobe_pos = 1'b0; // [RQ17]
			n.out.echo_strobe_neg = 1'b1;
			n.out.output_valid_flag = flag_src; // [RQ18]
			if (r.burst2.v) begin
				n.out.q = fwd(r.burst2.a, r.hold); // [RQ3] [RQ1]
				n.burst2.v = 1'b0;
			end
			if (r.wph.v) begin
				n.hold = r.wph; // [RQ7] [RQ13]
				n.hold.v = 1'b1;
				n.hold.d1 = r.s2.d;
				n.hold.m1 = ~r.s2.byte_write_sel_n; // [RQ10]
				n.wph.v = 1'b0;
			end
		end

		// AHB-Lite slave: zero wait states, always OKAY, reads answered from the address phase.
		n.hreadyout = 1'b1;
		n.hresp = HRESP_OKAY;
		n.a_ctrl_wr = 1'b0;
		if (r.a_ctrl_wr) begin
			n.ctrl = hwdata[1:0];
		end
		if (hsel && hready && htrans == HTRANS_NONSEQ) begin
			n.a_ctrl_wr = hwrite && haddr == REG_CTRL_OFS;
			if (!hwrite) begin
				n.hrdata = reg_rd(haddr, r);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r <= '0; // [RQ22]
			r.ctrl <= CTRL_RST;
			r.hreadyout <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// The array has no reset; only the posted pair from the holding register is written.
	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			mem[r.hold.a] <= merge(mem[r.hold.a], r.hold.d0, r.hold.m0); // [RQ7] [RQ10]
			mem[r.hold.a + ADDR_ONE] <= merge(mem[r.hold.a + ADDR_ONE], r.hold.d1, r.hold.m1);
		end
	end

	assign link_o = r.out;
	assign hrdata = r.hrdata;
	assign hreadyout = r.hreadyout;
	assign hresp = r.hresp;

	default clocking dbsp_cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_rd_issue;
		kpos && cmd_ok && !r.s2.load_strobe_n && r.s2.rw_sel;
	endsequence
	sequence s_wr_issue;
		kpos && cmd_ok && !r.s2.load_strobe_n && !r.s2.rw_sel;
	endsequence
	sequence s_rd_launched;
		r.rd1.v && !r.wcmd.v;
	endsequence

	AST_RD_CAPTURE: assert property (s_rd_issue |=> s_rd_launched ##0 r.rd1.a == $past(r.s2.addr)) // [RQ2]
		else $error("Read command not captured with its address.");
	AST_WR_CAPTURE: assert property (s_wr_issue |=> r.wcmd.v && !r.rd1.v && r.wcmd.a == $past(r.s2.addr)) // [RQ6]
		else $error("Write command not captured with its address.");
	AST_NOP: assert property (kpos && r.s2.load_strobe_n |=> !r.rd1.v && !r.wcmd.v) // [RQ25]
		else $error("Idle cycle started a transaction.");
	AST_RD_OUT: assert property (kpos && sel_v |=> r.out.q_oe && r.burst2.v && r.burst2.a == $past(sel_a) + ADDR_ONE) // [RQ3]
		else $error("Read burst did not start on the output bus.");
	AST_TRISTATE: assert property (kpos && !sel_v |=> !r.out.q_oe) // [RQ5]
		else $error("Read bus still driven with no read pending.");
	AST_ECHO_POS: assert property (kpos |=> r.out.echo_strobe_pos && !r.out.echo_strobe_neg) // [RQ17]
		else $error("Echo clocks wrong after positive edge.");
	AST_ECHO_NEG: assert property (kneg |=> !r.out.echo_strobe_pos && r.out.echo_strobe_neg) // [RQ17]
		else $error("Echo clocks wrong after negative edge.");
	// The flag must already stand when the first word of a burst is launched.
	AST_OUTPUT_VALID_FLAG: assert property (kpos && sel_v |-> r.out.output_valid_flag) // [RQ18]
		else $error("Valid flag not raised ahead of the first read word.");
	AST_HOLD: assert property (kneg && r.wph.v |=> r.hold.v && r.hold.a == $past(r.wph.a) ##1 !r.wph.v) // [RQ13]
		else $error("Completed write not placed in the holding register.");
	AST_STALL: assert property (!kpos && !kneg |=> $stable(r.out)) // [RQ25]
		else $error("Outputs changed without a link clock edge.");
	AST_LOCK: assert property ($rose(r.pll == PLL_LOCKED) |-> $past(r.lock_cnt) == LOCK_LAST) // [RQ19]
		else $error("PLL locked before the lock time elapsed.");
	AST_CAL: assert property (kpos && r.ctrl[CTRL_CAL_EN_BIT] && r.cal_cnt == RECAL_LAST
			|=> r.cal_total == $past(r.cal_total) + 16'h0001) // [RQ16]
		else $error("Recalibration not counted after 1024 cycles.");
	AST_LAT1: assert property (kpos && !lat2 && r.rd1.v
			|=> r.out.q_oe && r.burst2.v && r.burst2.a == $past(r.rd1.a) + ADDR_ONE) // [RQ21]
		else $error("Read without PLL did not answer after one cycle.");
	AST_LAT2: assert property (kpos && lat2 && r.rd2.v
			|=> r.out.q_oe && r.burst2.v && r.burst2.a == $past(r.rd2.a) + ADDR_ONE) // [RQ24]
		else $error("Read with PLL did not answer after two cycles.");
endmodule : dbsp_top

//--- testbench/dbsp_ctl_model.sv
// Purpose: Controller-side model that drives the link pins and captures read words.
// Assumes: The link clock runs with an 800 ns period, pauses while stop is set, and is unrelated in phase to ref_clk.
// Notes: Idle data and address lines show the inverse of their last value, so stale values never pass.
`timescale 1ns/100ps
module dbsp_ctl_model (
	output dbsp_pkg::dbsp_link_in_t link,
	input dbsp_pkg::dbsp_link_out_t lo
);
	import dbsp_pkg::*;
	typedef struct packed {
		logic rd;
		logic [ADDR_W-1:0] a;
		logic [WORD_W-1:0] d0;
		logic [WORD_W-1:0] d1;
		logic [BYTES-1:0] m0;
		logic [BYTES-1:0] m1;
	} dbsp_cmd_rec_t;
	dbsp_cmd_rec_t cq[$];
	dbsp_cmd_rec_t c;
	dbsp_cmd_rec_t wc;
	dbsp_cmd_rec_t wd;
	logic [21:0] got[$];
	logic stop = 1'b0;
	logic lat_one = 1'b0;
	logic rnow = 1'b0;
	logic wnow = 1'b0;
	logic wdv = 1'b0;
	logic rlast = 1'b0;
	logic gap = 1'b0;
	logic [3:0] rp = 4'h0;
	int kcnt = 0;
	int li;
	task automatic put(input dbsp_cmd_rec_t x);
		cq.push_back(x);
	endtask : put
	function automatic logic quiet();
		return cq.size() == 0 && rp == 4'h0 && !rnow && !wnow && !wdv;
	endfunction : quiet
	initial begin
		link = '0;
		link.k_n = 1'b1;
		link.load_strobe_n = 1'b1;
		#33;
		forever begin
			wait (!stop);
			link.pll_bypass_n = !lat_one;
			li = lat_one ? 1 : 2;
			link.k = 1'b1;
			link.k_n = 1'b0;
			kcnt++;
			rp = {rp[2:0], rnow};
			rnow = 1'b0;
			#200;
			link.d = wdv ? wd.d1 : ~link.d;
			link.byte_write_sel_n = wdv ? wd.m1 : ~link.byte_write_sel_n;
			wdv = 1'b0;
			// Only a driven bus counts, so a lost or refused read shows up in the word count.
			if (rp[li + 1] && lo.q_oe) begin
				got.push_back({lo.echo_strobe_neg, lo.echo_strobe_pos, lo.q_oe, lo.output_valid_flag, lo.q});
			end
			#200;
			link.k = 1'b0;
			link.k_n = 1'b1;
			#200;
			if (rp[li] && lo.q_oe) begin
				got.push_back({lo.echo_strobe_neg, lo.echo_strobe_pos, lo.q_oe, lo.output_valid_flag, lo.q});
			end
			if (wnow) wd = wc;
			link.d = wnow ? wd.d0 : ~link.d;
			link.byte_write_sel_n = wnow ? wd.m0 : ~link.byte_write_sel_n;
			wdv = wnow;
			wnow = 1'b0;
			link.load_strobe_n = 1'b1;
			link.rw_sel = ~link.rw_sel;
			link.addr = ~link.addr;
			if (gap) begin
				gap = 1'b0;
			end else if (cq.size() > 0 && !cq[0].rd && rlast) begin
				// Two idle cycles keep the read bus clear of the coming write.
				rlast = 1'b0;
				gap = 1'b1;
			end else if (cq.size() > 0) begin
				c = cq.pop_front();
				link.load_strobe_n = 1'b0;
				link.rw_sel = c.rd;
				link.addr = c.a;
				rlast = c.rd;
				rnow = c.rd;
				wnow = !c.rd;
				wc = c;
			end
			#200;
		end
	end
endmodule : dbsp_ctl_model

//--- testbench/ddr_burst2_sram_port_tb.sv
// Purpose: Self-checking bench for the burst-of-two memory port.
// Assumes: The controller model drives the link; AHB-Lite reaches the status registers.
// Notes: Expected read data comes from a byte-merged shadow of every queued write.
`timescale 1ns/100ps
module ddr_burst2_sram_port_tb;
	import dbsp_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	dbsp_link_in_t link_i;
	dbsp_link_out_t link_o;
	int err_count = 0;
	int checks = 0;
	int j;
	logic [17:0] mem [logic [19:0]];
	logic [21:0] exq[$];
	logic [19:0] tab [4] = '{20'h00010, 20'h00020, 20'hfffff, 20'h00100};
	logic [31:0] rd;
	dbsp_top i_dbsp_top (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link_i(link_i), .link_o(link_o));
	dbsp_ctl_model i_dbsp_ctl_model (.link(link_i), .lo(link_o));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wdat, output logic [31:0] r);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wdat;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
	endtask : ahb
	function automatic logic [17:0] mrg(input logic [17:0] o, input logic [17:0] n, input logic [1:0] m);
		return {m[1] ? o[17:9] : n[17:9], m[0] ? o[8:0] : n[8:0]};
	endfunction : mrg
	task automatic wr(input logic [19:0] a, input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m0,
		input logic [1:0] m1);
		mem[a] = mrg(mem.exists(a) ? mem[a] : 18'h0, d0, m0);
		mem[a + 20'h1] = mrg(mem.exists(a + 20'h1) ? mem[a + 20'h1] : 18'h0, d1, m1);
		i_dbsp_ctl_model.put({1'b0, a, d0, d1, m0, m1});
	endtask : wr
	task automatic rdq(input logic [19:0] a);
		i_dbsp_ctl_model.put({1'b1, a, 36'h0, 4'h0});
		exq.push_back({4'h7, mem[a]});
		exq.push_back({4'ha, mem[a + 20'h1]});
	endtask : rdq
	task automatic drain();
		logic [21:0] g;
		logic [21:0] e;
		int n;
		n = 0;
		while (!i_dbsp_ctl_model.quiet() && n < 30000) begin
			@(posedge ref_clk);
			n++;
		end
		chk("drain_done", {31'h0, i_dbsp_ctl_model.quiet()}, 32'h1);
		repeat (40) @(posedge ref_clk);
		chk("rd_count", 32'(i_dbsp_ctl_model.got.size()), 32'(exq.size()));
		while (exq.size() > 0 && i_dbsp_ctl_model.got.size() > 0) begin
			g = i_dbsp_ctl_model.got.pop_front();
			e = exq.pop_front();
			chk("rd_word", {10'h0, g & {3'h7, e[18], 18'h3ffff}}, {10'h0, e});
		end
		exq.delete();
		i_dbsp_ctl_model.got.delete();
		chk("q_oe_idle", {31'h0, link_o.q_oe}, 32'h0);
	endtask : drain
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		#4000000;
		err_count++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'hb24f));
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		chk("q_oe_reset", {31'h0, link_o.q_oe}, 32'h0);
		ahb(1'b0, REG_CTRL_OFS, 32'h0, rd);
		chk("ctrl_reset", rd, {30'h0, CTRL_RST});
		ahb(1'b0, 32'h0000000c, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		repeat (400) @(posedge ref_clk);
		ahb(1'b0, REG_STATUS_OFS, 32'h0, rd);
		chk("pll_lock", rd, 32'h3);
		i_dbsp_ctl_model.stop = 1'b1;
		repeat (40) @(posedge ref_clk);
		ahb(1'b0, REG_STATUS_OFS, 32'h0, rd);
		chk("pll_stop", {31'h0, rd[ST_LOCK_BIT]}, 32'h0);
		i_dbsp_ctl_model.stop = 1'b0;
		repeat (400) @(posedge ref_clk);
		ahb(1'b0, REG_STATUS_OFS, 32'h0, rd);
		chk("pll_relock", {31'h0, rd[ST_LOCK_BIT]}, 32'h1);
		for (int p = 0; p < 2; p++) begin
			i_dbsp_ctl_model.lat_one = p[0];
			repeat (40) @(posedge ref_clk);
			ahb(1'b0, REG_STATUS_OFS, 32'h0, rd);
			chk("pll_mode", {30'h0, rd[1:0]}, p[0] ? 32'h0 : 32'h3);
			// Full-mask writes first, so no read can meet an unwritten word.
			foreach (tab[i]) wr(tab[i], 18'($urandom()), 18'($urandom()), 2'h0, 2'h0);
			foreach (tab[i]) rdq(tab[i]);
			for (int n = 0; n < 40; n++) begin
				j = $urandom_range(0, 3);
				if ($urandom_range(0, 1)) begin
					rdq(tab[j]);
				end else begin
					wr(tab[j], 18'($urandom()), 18'($urandom()), 2'($urandom()), 2'($urandom()));
					rdq(tab[j]);
				end
			end
			drain();
			ahb(1'b0, REG_STATUS_OFS, 32'h0, rd);
			chk("posted", {30'h0, rd[ST_QOE_BIT], rd[ST_HOLD_BIT]}, 32'h1);
		end
		while (i_dbsp_ctl_model.kcnt < 2100) @(posedge ref_clk);
		ahb(1'b0, REG_CALCNT_OFS, 32'h0, rd);
		chk("recal", rd, 32'h2);
		ahb(1'b1, REG_CTRL_OFS, 32'h1, rd);
		ahb(1'b0, REG_CTRL_OFS, 32'h0, rd);
		chk("ctrl_rw", rd, 32'h1);
		// Link commands are disabled now, so this read must leave the bus floating and return no word.
		i_dbsp_ctl_model.put({1'b1, tab[0], 36'h0, 4'h0});
		drain();
		report_and_stop();
	end
endmodule : ddr_burst2_sram_port_tb
